// >>> amrc_pkg.sv
// Purpose: Shared constants for the audio mix and rate converter block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are word indices; byte address is index times four
package amrc_pkg;

  // Register word indices and byte address width
  localparam int unsigned    ADDR_W          = 18;
  localparam logic [15:0]    IDX_OFS_CFG     = 16'hfec1;
  localparam logic [15:0]    IDX_OFS_L_LO    = 16'hfec2;
  localparam logic [15:0]    IDX_OFS_L_HI    = 16'hfec3;
  localparam logic [15:0]    IDX_OFS_R_LO    = 16'hfec4;
  localparam logic [15:0]    IDX_OFS_R_HI    = 16'hfec5;
  localparam logic [15:0]    IDX_CNV_CFG     = 16'hfec6;
  localparam logic [15:0]    IDX_CNV_L_LO    = 16'hfec7;
  localparam logic [15:0]    IDX_CNV_L_HI    = 16'hfec8;
  localparam logic [15:0]    IDX_CNV_R_LO    = 16'hfec9;
  localparam logic [15:0]    IDX_CNV_R_HI    = 16'hfeca;

  // Configuration register field positions
  localparam int unsigned    OFS_URUN_BIT    = 14;
  localparam int unsigned    OFS_FULL_BIT    = 13;
  localparam int unsigned    OFS_ENA_BIT     = 12;
  localparam int unsigned    CNV_ORUN_BIT    = 15;
  localparam int unsigned    CNV_RFULL_BIT   = 14;
  localparam int unsigned    CNV_LFULL_BIT   = 13;
  localparam int unsigned    CNV_ENA_BIT     = 12;
  localparam int unsigned    RATE_MSB        = 11;

  // Reset values
  localparam logic [15:0]    REG_RESET       = 16'h0000;
  localparam logic [11:0]    RATE_RESET      = 12'h000;

  // Mixer saturation limits, 20-bit signed
  localparam logic [19:0]    SAT_MAX         = 20'h7_ffff;
  localparam logic [19:0]    SAT_MIN         = 20'h8_0000;

  // Main-path samples before converter output is trusted
  localparam logic [4:0]     CNV_START_COUNT = 5'h13;

  // APB slave phase, one-hot
  typedef enum logic [1:0] {
    AMRC_BUS_IDLE = 2'b01,
    AMRC_BUS_DONE = 2'b10
  } amrc_bus_type;

endpackage : amrc_pkg

// >>> amrc_top.sv
// Purpose: Secondary audio offset mixer and filterless rate converter
// Assumes: Main-path samples and strobe arrive on the same clock
// Notes:   APB slave with one wait state; all outputs are registered
`timescale 1ns/1ps
module amrc_top
  import amrc_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Main playback path in
  input  wire logic [19:0]         mix_in_left,
  input  wire logic [19:0]         mix_in_right,
  input  wire logic [23:0]         main_left,
  input  wire logic [23:0]         main_right,
  input  wire logic                main_sample_stb,
  // Mixed stream out
  output logic      [19:0]         mix_out_left,
  output logic      [19:0]         mix_out_right,
  // Events and status
  output logic                     offset_irq,
  output logic                     converter_irq,
  output logic                     converter_valid
);

  // ---------------- APB slave ----------------
  amrc_bus_type       bus_q;
  amrc_bus_type       bus_d;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  logic [15:0]        rdata;

  // Word index and per-register hits
  wire logic [15:0]   idx       = paddr[ADDR_W-1:2];
  wire logic          aligned   = (paddr[1:0] == 2'b00);
  wire logic          hit_ocfg  = aligned && (idx == IDX_OFS_CFG);
  wire logic          hit_oll   = aligned && (idx == IDX_OFS_L_LO);
  wire logic          hit_olh   = aligned && (idx == IDX_OFS_L_HI);
  wire logic          hit_orl   = aligned && (idx == IDX_OFS_R_LO);
  wire logic          hit_orh   = aligned && (idx == IDX_OFS_R_HI);
  wire logic          hit_ccfg  = aligned && (idx == IDX_CNV_CFG);
  wire logic          hit_cll   = aligned && (idx == IDX_CNV_L_LO);
  wire logic          hit_clh   = aligned && (idx == IDX_CNV_L_HI);
  wire logic          hit_crl   = aligned && (idx == IDX_CNV_R_LO);
  wire logic          hit_crh   = aligned && (idx == IDX_CNV_R_HI);
  wire logic          hit_any   = hit_ocfg | hit_oll | hit_olh | hit_orl | hit_orh |
                                  hit_ccfg | hit_cll | hit_clh | hit_crl | hit_crh;

  // Transfer completes on the edge where pready is seen high
  wire logic          xfer_done = psel && penable && (bus_q == AMRC_BUS_DONE);
  wire logic          wr_en     = xfer_done && pwrite;
  wire logic          rd_en     = xfer_done && !pwrite;
  wire logic [15:0]   wd        = pwdata[15:0];

  // Phase step: one wait state lets read data come from a flop
  always_comb begin
    case (bus_q)
      AMRC_BUS_IDLE: bus_d = (psel && penable) ? AMRC_BUS_DONE : AMRC_BUS_IDLE;
      AMRC_BUS_DONE: bus_d = AMRC_BUS_IDLE;
      default:       bus_d = AMRC_BUS_IDLE;
    endcase
  end

  // Bus phase and captured answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_q     <= AMRC_BUS_IDLE;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      if (bus_q == AMRC_BUS_IDLE && psel && penable) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : {16'h0000, rdata};
        pslverr_q <= !hit_any;
      end
    end
  end

  assign prdata  = prdata_q;
  // Done bit of the one-hot phase flop, no gate in the path
  assign pready  = bus_q[1];
  assign pslverr = pslverr_q;

  // ---------------- Offset mixer state ----------------
  logic               ofs_ena_q;
  logic [11:0]        ofs_rate_q;
  logic               ofs_full_q;
  logic               ofs_urun_q;
  logic [15:0]        ofs_l_hi_q;
  logic [3:0]         ofs_l_lo_q;
  logic [15:0]        ofs_r_hi_q;
  logic [3:0]         ofs_r_lo_q;
  logic [19:0]        held_l_q;
  logic [19:0]        held_r_q;
  logic [11:0]        ofs_cnt_q;
  logic               offset_irq_q;
  logic [19:0]        mix_l_q;
  logic [19:0]        mix_r_q;

  wire logic          ofs_fetch    = ofs_ena_q && (ofs_cnt_q == ofs_rate_q);
  wire logic          ofs_full_set = wr_en && hit_orh;
  wire logic          ofs_urun_clr = wr_en && hit_ocfg && !wd[OFS_URUN_BIT];

  // Interval counter; stops at zero while disabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ofs_cnt_q <= RATE_RESET;
    end else begin
      ofs_cnt_q <= (!ofs_ena_q || ofs_fetch) ? RATE_RESET : ofs_cnt_q + 12'h001;
    end
  end

  // Offset configuration and sample registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ofs_ena_q  <= 1'b0;
      ofs_rate_q <= RATE_RESET;
      ofs_l_hi_q <= REG_RESET;
      ofs_l_lo_q <= 4'h0;
      ofs_r_hi_q <= REG_RESET;
      ofs_r_lo_q <= 4'h0;
    end else begin
      if (wr_en && hit_ocfg) begin
        ofs_ena_q  <= wd[OFS_ENA_BIT];
        ofs_rate_q <= wd[RATE_MSB:0];
      end
      // Low word uses only upper nibble
      if (wr_en && hit_oll) ofs_l_lo_q <= wd[15:12];
      if (wr_en && hit_olh) ofs_l_hi_q <= wd;
      if (wr_en && hit_orl) ofs_r_lo_q <= wd[15:12];
      if (wr_en && hit_orh) ofs_r_hi_q <= wd;
    end
  end

  // Offset flags; a same-cycle set beats the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ofs_full_q <= 1'b0;
      ofs_urun_q <= 1'b0;
    end else begin
      if (ofs_full_set)   ofs_full_q <= 1'b1;
      else if (ofs_fetch) ofs_full_q <= 1'b0;
      if (ofs_fetch && !ofs_full_q) ofs_urun_q <= 1'b1;
      else if (ofs_urun_clr)        ofs_urun_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_l_q     <= 20'h0_0000;
      held_r_q     <= 20'h0_0000;
      offset_irq_q <= 1'b0;
    end else begin
      if (ofs_fetch) begin
        held_l_q <= {ofs_l_hi_q, ofs_l_lo_q};
        held_r_q <= {ofs_r_hi_q, ofs_r_lo_q};
      end
      offset_irq_q <= ofs_fetch;
    end
  end

  wire logic [19:0]   add_l = ofs_ena_q ? held_l_q : 20'h0_0000;
  wire logic [19:0]   add_r = ofs_ena_q ? held_r_q : 20'h0_0000;
  // Widen by one bit so overflow shows
  wire logic [20:0]   sum_l = {mix_in_left[19], mix_in_left} + {add_l[19], add_l};
  wire logic [20:0]   sum_r = {mix_in_right[19], mix_in_right} + {add_r[19], add_r};
  wire logic [19:0]   sat_l = (sum_l[20] == sum_l[19]) ? sum_l[19:0] :
                              (sum_l[20] ? SAT_MIN : SAT_MAX);
  wire logic [19:0]   sat_r = (sum_r[20] == sum_r[19]) ? sum_r[19:0] :
                              (sum_r[20] ? SAT_MIN : SAT_MAX);

  // Registered mix output, one cycle of latency
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mix_l_q <= 20'h0_0000;
      mix_r_q <= 20'h0_0000;
    end else begin
      mix_l_q <= sat_l;
      mix_r_q <= sat_r;
    end
  end

  assign mix_out_left  = mix_l_q;
  assign mix_out_right = mix_r_q;
  assign offset_irq    = offset_irq_q;

  // ---------------- Rate converter state ----------------
  logic               cnv_ena_q;
  logic [11:0]        cnv_rate_q;
  logic               cnv_orun_q;
  logic               cnv_lfull_q;
  logic               cnv_rfull_q;
  logic [23:0]        tap_l_q;
  logic [23:0]        tap_r_q;
  logic [23:0]        cnv_l_q;
  logic [23:0]        cnv_r_q;
  logic [12:0]        cnv_cnt_q;
  logic [4:0]         cnv_seen_q;
  logic               converter_irq_q;
  logic               converter_valid_q;

  // Interval is twice the field plus two counts
  wire logic [12:0]   cnv_last  = {cnv_rate_q, 1'b1};
  wire logic          cnv_store = cnv_ena_q && (cnv_cnt_q == cnv_last);
  wire logic          cnv_orun_clr = wr_en && hit_ccfg && !wd[CNV_ORUN_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tap_l_q <= 24'h00_0000;
      tap_r_q <= 24'h00_0000;
    end else if (main_sample_stb) begin
      tap_l_q <= main_left;
      tap_r_q <= main_right;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnv_cnt_q <= 13'h0000;
    end else begin
      cnv_cnt_q <= (!cnv_ena_q || cnv_store) ? 13'h0000 : cnv_cnt_q + 13'h0001;
    end
  end

  // Converter configuration; software may also write samples
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnv_ena_q  <= 1'b0;
      cnv_rate_q <= RATE_RESET;
      cnv_l_q    <= 24'h00_0000;
      cnv_r_q    <= 24'h00_0000;
    end else begin
      if (wr_en && hit_ccfg) begin
        cnv_ena_q  <= wd[CNV_ENA_BIT];
        cnv_rate_q <= wd[RATE_MSB:0];
      end
      if (cnv_store) begin
        cnv_l_q <= tap_l_q;
        cnv_r_q <= tap_r_q;
      end else begin
        if (wr_en && hit_clh) cnv_l_q[23:8] <= wd;
        if (wr_en && hit_cll) cnv_l_q[7:0]  <= wd[15:8];
        if (wr_en && hit_crh) cnv_r_q[23:8] <= wd;
        if (wr_en && hit_crl) cnv_r_q[7:0]  <= wd[15:8];
      end
    end
  end

  // Converter flags; store beats a read clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnv_lfull_q <= 1'b0;
      cnv_rfull_q <= 1'b0;
      cnv_orun_q  <= 1'b0;
    end else begin
      // Full flags set on store, clear on read of the high word
      if (cnv_store)             cnv_lfull_q <= 1'b1;
      else if (rd_en && hit_clh) cnv_lfull_q <= 1'b0;
      if (cnv_store)             cnv_rfull_q <= 1'b1;
      else if (rd_en && hit_crh) cnv_rfull_q <= 1'b0;
      if (cnv_store && (cnv_lfull_q || cnv_rfull_q)) cnv_orun_q <= 1'b1;
      else if (cnv_orun_clr)                         cnv_orun_q <= 1'b0;
    end
  end

  // Count main samples until output trusted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnv_seen_q        <= 5'h00;
      converter_valid_q <= 1'b0;
      converter_irq_q   <= 1'b0;
    end else begin
      if (!cnv_ena_q)
        cnv_seen_q <= 5'h00;
      else if (main_sample_stb && cnv_seen_q != CNV_START_COUNT)
        cnv_seen_q <= cnv_seen_q + 5'h01;
      converter_valid_q <= cnv_ena_q && (cnv_seen_q == CNV_START_COUNT);
      converter_irq_q <= cnv_store;
    end
  end

  assign converter_irq   = converter_irq_q;
  assign converter_valid = converter_valid_q;

  // ---------------- Read data selection ----------------
  wire logic [15:0]   ocfg_rd = {1'b0, ofs_urun_q, ofs_full_q, ofs_ena_q, ofs_rate_q};
  wire logic [15:0]   ccfg_rd = {cnv_orun_q, cnv_rfull_q, cnv_lfull_q, cnv_ena_q, cnv_rate_q};
  // AND-OR mux keeps the decode flat
  assign rdata = ({16{hit_ocfg}} & ocfg_rd)                  |
                 ({16{hit_oll}}  & {ofs_l_lo_q, 12'h000})    |
                 ({16{hit_olh}}  & ofs_l_hi_q)               |
                 ({16{hit_orl}}  & {ofs_r_lo_q, 12'h000})    |
                 ({16{hit_orh}}  & ofs_r_hi_q)               |
                 ({16{hit_ccfg}} & ccfg_rd)                  |
                 ({16{hit_cll}}  & {cnv_l_q[7:0], 8'h00})    |
                 ({16{hit_clh}}  & cnv_l_q[23:8])            |
                 ({16{hit_crl}}  & {cnv_r_q[7:0], 8'h00})    |
                 ({16{hit_crh}}  & cnv_r_q[23:8]);

  // ---------------- Checks ----------------
  sat_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sum_l[20] == 1'b0 && sum_l[19] == 1'b1) |=> (mix_out_left == SAT_MAX))
    else $error("positive overflow not clamped");

  zero_mix_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ofs_ena_q |=> (mix_out_left == $past(mix_in_left)))
    else $error("disabled mixer altered main sample");

  fetch_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    ofs_fetch |=> offset_irq ##1 (offset_irq == $past(ofs_fetch)))
    else $error("offset interrupt pulse missing");

  underrun_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ofs_fetch && !ofs_full_q) |=> ofs_urun_q)
    else $error("underrun not flagged");

  full_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ofs_fetch && !ofs_full_set) |=> !ofs_full_q)
    else $error("offset full not cleared by fetch");

  offset_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ofs_ena_q |-> !ofs_fetch ##1 !offset_irq)
    else $error("offset fetch while disabled");

  conv_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    cnv_store |=> converter_irq && cnv_lfull_q && cnv_rfull_q)
    else $error("converter store without pulse and flags");

  conv_orun_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cnv_store && cnv_lfull_q) |=> cnv_orun_q)
    else $error("converter overrun missed");

  conv_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    !cnv_ena_q |=> !converter_irq)
    else $error("converter stored while disabled");

  conv_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cnv_seen_q != CNV_START_COUNT) |=> !converter_valid)
    else $error("converter valid too early");

endmodule : amrc_top

// >>> amrc_dac_model.sv
// Purpose: Behavioural main playback path feeding the mixer and converter
// Assumes: Same clock as the block; bench chooses the mix stream levels
// Notes:   Main-path samples are fixed so converter readback is predictable
`timescale 1ns/1ps
module amrc_dac_model #(
  parameter int          STB_PERIOD = 20,
  parameter logic [23:0] LEFT_SMP   = 24'ha1_b2c3,
  parameter logic [23:0] RIGHT_SMP  = 24'h5d_6e7f
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Levels chosen by the bench
  input  wire logic [19:0] set_mix_l,
  input  wire logic [19:0] set_mix_r,
  // Playback stream toward the block
  output logic      [19:0] mix_in_left,
  output logic      [19:0] mix_in_right,
  output logic      [23:0] main_left,
  output logic      [23:0] main_right,
  output logic             main_sample_stb
);
  logic [7:0] tick_q;
  logic       wrap;

  // Last tick of a sample period
  assign wrap = (tick_q == 8'(STB_PERIOD - 1));

  // One strobe per sample; levels move only just after an edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_q          <= 8'h00;
      main_sample_stb <= 1'b0;
      main_left       <= 24'h00_0000;
      main_right      <= 24'h00_0000;
      mix_in_left     <= 20'h0_0000;
      mix_in_right    <= 20'h0_0000;
    end else begin
      tick_q          <= wrap ? 8'h00 : tick_q + 8'h01;
      main_sample_stb <= wrap;
      main_left       <= LEFT_SMP;
      main_right      <= RIGHT_SMP;
      mix_in_left     <= set_mix_l;
      mix_in_right    <= set_mix_r;
    end
  end
endmodule : amrc_dac_model

// >>> amrc_top_bench.sv
// Purpose: Self-checking bench for the offset mixer and rate converter
// Assumes: APB answers when it is ready; the master never counts on latency
// Notes:   Interval checks count edges between two interrupt pulses
`timescale 1ns/1ps
module amrc_top_bench;
  import amrc_pkg::*;
  logic                clock   = 1'b0;
  logic                rst_n   = 1'b0;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [ADDR_W-1:0]   paddr   = '0;
  logic [31:0]         pwdata  = 32'h0000_0000;
  // Bench levels stay below three quarters of full scale at first
  // Keep mix modest
  logic [19:0]         mix_l   = 20'h0_1000;
  logic [19:0]         mix_r   = 20'h0_0010;
  logic [31:0]         prdata;
  logic                pready, pslverr, offset_irq, converter_irq, converter_valid;
  logic [19:0]         mix_in_left, mix_in_right, mix_out_left, mix_out_right;
  logic [23:0]         main_left, main_right;
  logic                main_sample_stb;
  int                  num_errors = 0;
  int                  n_compared = 0;
  int                  n;
  logic [31:0]         r;
  logic                e;

  always #5 clock = ~clock;

  amrc_dac_model i_amrc_dac_model (.clock(clock), .rst_n(rst_n), .set_mix_l(mix_l),
    .set_mix_r(mix_r), .mix_in_left(mix_in_left), .mix_in_right(mix_in_right),
    .main_left(main_left), .main_right(main_right), .main_sample_stb(main_sample_stb));

  amrc_top i_amrc_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mix_in_left(mix_in_left), .mix_in_right(mix_in_right),
    .main_left(main_left), .main_right(main_right), .main_sample_stb(main_sample_stb),
    .mix_out_left(mix_out_left), .mix_out_right(mix_out_right), .offset_irq(offset_irq),
    .converter_irq(converter_irq), .converter_valid(converter_valid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  // One APB transfer; a spare edge after release keeps drives apart
  task automatic apb(input bit wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk_n(k, 0);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, idx, d, x, y);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, idx, 32'h0000_0000, x, y);
    chk(x, exp);
  endtask : rdc

  // Edges until the chosen pulse; lim+1 means none came
  task automatic wait_irq(input bit cnv, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      cnt++;
    end while ((cnv ? converter_irq : offset_irq) !== 1'b1 && cnt <= lim);
  endtask : wait_irq

  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 10; i++) rdc(16'(IDX_OFS_CFG + i), 32'h0000_0000);
    apb(1'b0, 16'hfecb, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    apb(1'b1, 16'hfec0, 32'h0000_ffff, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    // Offset samples: left 0x12345, right 0xedcba
    wr(IDX_OFS_L_LO, 32'h0000_5000);
    wr(IDX_OFS_L_HI, 32'h0000_1234);
    wr(IDX_OFS_R_LO, 32'h0000_a000);
    wr(IDX_OFS_R_HI, 32'h0000_edcb);
    rdc(IDX_OFS_CFG, 32'h0000_2000);
    rdc(IDX_OFS_L_HI, 32'h0000_1234);
    rdc(IDX_OFS_L_LO, 32'h0000_5000);
    wr(IDX_OFS_CFG, 32'h0000_1009);
    wait_irq(1'b0, 100, n);
    wait_irq(1'b0, 100, n);
    chk_n(n, 10);
    rdc(IDX_OFS_CFG, 32'h0000_5009);
    chk({12'h0, mix_out_left}, 32'h0001_3345);
    chk({12'h0, mix_out_right}, 32'h000e_dcca);
    mix_l <= 20'h7_0000;
    mix_r <= 20'h8_0000;
    repeat (4) @(posedge clock);
    chk({12'h0, mix_out_left}, 32'h0007_ffff);
    chk({12'h0, mix_out_right}, 32'h0008_0000);
    wr(IDX_OFS_CFG, 32'h0000_0009);
    rdc(IDX_OFS_CFG, 32'h0000_0009);
    chk({12'h0, mix_out_left}, 32'h0007_0000);
    wait_irq(1'b0, 30, n);
    chk_n(n, 31);
    // Converter: rate 0x3f gives one store per 128 edges
    wr(IDX_CNV_CFG, 32'h0000_103f);
    wait_irq(1'b1, 300, n);
    wait_irq(1'b1, 300, n);
    chk_n(n, 128);
    rdc(IDX_CNV_CFG, 32'h0000_f03f);
    rdc(IDX_CNV_L_HI, 32'h0000_a1b2);
    rdc(IDX_CNV_CFG, 32'h0000_d03f);
    rdc(IDX_CNV_L_LO, 32'h0000_c300);
    rdc(IDX_CNV_R_HI, 32'h0000_5d6e);
    rdc(IDX_CNV_R_LO, 32'h0000_7f00);
    rdc(IDX_CNV_CFG, 32'h0000_903f);
    wr(IDX_CNV_CFG, 32'h0000_103f);
    rdc(IDX_CNV_CFG, 32'h0000_103f);
    wait_irq(1'b1, 300, n);
    chk({31'h0, converter_irq}, 32'h0000_0001);
    // Restart count of main samples before output is trusted
    wr(IDX_CNV_CFG, 32'h0000_003f);
    // Valid flop drops one edge after the enable flop
    @(posedge clock);
    chk({31'h0, converter_valid}, 32'h0000_0000);
    wait_irq(1'b1, 300, n);
    chk_n(n, 301);
    // Enable just after a strobe so bench and block count the same strobes
    @(posedge clock iff main_sample_stb);
    wr(IDX_CNV_CFG, 32'h0000_103f);
    repeat (18) @(posedge clock iff main_sample_stb);
    chk({31'h0, converter_valid}, 32'h0000_0000);
    // Nineteenth strobe, then count flop and valid flop
    @(posedge clock iff main_sample_stb);
    repeat (2) @(posedge clock);
    chk({31'h0, converter_valid}, 32'h0000_0001);
    test_done();
  end
endmodule : amrc_top_bench
